// *** rtl/tpwm_pkg.sv ***
// package: register map, fields and modes of the three-phase pwm timer
package tpwm_pkg;
    localparam int TPWM_DW = 16;
    // byte addresses of the register words
    localparam logic [7:0] TPWM_A_START = 8'h00;
    localparam logic [7:0] TPWM_A_TCR3 = 8'h04;
    localparam logic [7:0] TPWM_A_TCR4 = 8'h08;
    localparam logic [7:0] TPWM_A_MODE3 = 8'h0C;
    localparam logic [7:0] TPWM_A_MODE4 = 8'h10;
    localparam logic [7:0] TPWM_A_OCR = 8'h14;
    localparam logic [7:0] TPWM_A_OER = 8'h18;
    localparam logic [7:0] TPWM_A_CNT3 = 8'h1C;
    localparam logic [7:0] TPWM_A_CNT4 = 8'h20;
    localparam logic [7:0] TPWM_A_PER = 8'h24;
    localparam logic [7:0] TPWM_A_PERBUF = 8'h28;
    localparam logic [7:0] TPWM_A_DUTY0 = 8'h2C;
    localparam logic [7:0] TPWM_A_BUF0 = 8'h38;
    localparam logic [7:0] TPWM_A_DEAD = 8'h44;
    localparam logic [7:0] TPWM_A_CYC = 8'h48;
    localparam logic [7:0] TPWM_A_CYCBUF = 8'h4C;
    localparam logic [7:0] TPWM_A_SUB = 8'h50;
    localparam logic [7:0] TPWM_A_BCR = 8'h54;
    // fields
    localparam int TPWM_B_CH3_COUNT_START = 6;
    localparam int TPWM_B_CH4_COUNT_START = 7;
    localparam int TPWM_B_PERIOD_TOGGLE_ENABLE = 6;
    localparam int TPWM_B_NEGATIVE_LEVEL_SELECT = 1;
    localparam int TPWM_B_POSITIVE_LEVEL_SELECT = 0;
    localparam int TPWM_B_ACCESS = 13;
    localparam logic [3:0] TPWM_MD_RESET_SYNC = 4'h8;
    localparam logic [3:0] TPWM_MD_COMP_CREST = 4'hD;
    localparam logic [3:0] TPWM_MD_COMP_TROUGH = 4'hE;
    localparam logic [3:0] TPWM_MD_COMP_BOTH = 4'hF;
    localparam logic [7:0] TPWM_TCR_RST = 8'h00;
    localparam logic [7:0] TPWM_OER_RST = 8'hC0;
    localparam logic [15:0] TPWM_BCR_RST = 16'h0000;
    localparam logic [TPWM_DW-1:0] TPWM_CNT_MAX = 16'hFFFF;
    localparam logic [TPWM_DW-1:0] TPWM_ZERO = 16'h0000;
    localparam logic [TPWM_DW-1:0] TPWM_ONE = 16'h0001;
    localparam logic [2:0] TPWM_PSC_MAX = 3'h3;

    // apb request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tpwm_apb_req_t;

    // six gate outputs plus the period toggle pin
    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
        logic toggle;
    } tpwm_pins_t;
endpackage

// *** rtl/tpwm_tick.sv ***
// counter clock prescaler and edge selection
`timescale 1ns/1ps
module tpwm_tick import tpwm_pkg::*; #(
    parameter int PW = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic run,
    input wire logic [2:0] psc_sel,
    input wire logic [1:0] edge_sel,
    // count strobe
    output logic tick
);
    typedef struct packed {
        logic [PW-1:0] div;
        logic prev;
        logic tick;
    } tpwm_tick_st_t;
    tpwm_tick_st_t s_q, s_d;
    logic tap;

    // divided clock tap: clk/1, /4, /16, /64 for prescaler 0..3
    always_comb begin
        s_d = s_q;
        tap = 1'b1;
        if (psc_sel != 3'h0) begin
            tap = s_q.div[2 * (psc_sel > TPWM_PSC_MAX ? int'(TPWM_PSC_MAX) : int'(psc_sel)) - 1];
        end
        s_d.div = run ? s_q.div + PW'(1) : '0;
        s_d.prev = tap;
        if (psc_sel == 3'h0) begin
            s_d.tick = run;
        end else begin
            unique case (edge_sel)
                2'h0: s_d.tick = run & tap & ~s_q.prev;
                2'h1: s_d.tick = run & ~tap & s_q.prev;
                default: s_d.tick = run & (tap ^ s_q.prev);
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// *** rtl/tpwm_top.sv ***
// three-phase pwm timer, channels three and four, with apb registers
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module tpwm_top import tpwm_pkg::*; #(
    parameter int DW = TPWM_DW
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // gate driver pins
    output tpwm_pins_t pins,
    output logic [6:0] pins_oe_b
);
    typedef struct packed {
        logic [1:0] start;
        logic [7:0] tcr3;
        logic [7:0] tcr4;
        logic [3:0] mode3;
        logic [3:0] mode4;
        logic [7:0] ocr;
        logic [7:0] oer;
        logic [15:0] bcr;
        logic [DW-1:0] cnt3;
        logic [DW-1:0] cnt4;
        logic [DW-1:0] sub;
        logic [DW-1:0] per;
        logic [DW-1:0] perbuf;
        logic [DW-1:0] dead;
        logic [DW-1:0] cyc;
        logic [DW-1:0] cycbuf;
        logic [2:0][DW-1:0] duty;
        logic [2:0][DW-1:0] buf_r;
        logic [2:0][DW-1:0] temp;
        logic down;
        logic [2:0] phase;
        logic [2:0] pos;
        logic [2:0] neg;
        logic toggle;
        logic [6:0] oe_b;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } tpwm_st_t;
    tpwm_st_t s_q, s_d;
    tpwm_apb_req_t req;
    logic tick, rsync, comp, locked;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // word index of a duty or buffer register, 3 if none
    function automatic logic [1:0] idx3(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] off;
        off = a - base;
        idx3 = (a >= base && off < 8'h0C && off[1:0] == 2'h0) ? off[3:2] : 2'h3;
    endfunction

    function automatic logic [31:0] zx(input logic [DW-1:0] v);
        zx = 32'(v);
    endfunction

    assign rsync = s_q.mode3 == TPWM_MD_RESET_SYNC;
    assign comp = s_q.mode3 >= TPWM_MD_COMP_CREST;
    assign locked = ~s_q.bcr[TPWM_B_ACCESS];

    // one count strobe from channel-three clock select
    tpwm_tick u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .run(s_q.start[0] & s_q.start[1]),
        .psc_sel(s_q.tcr3[2:0]),
        .edge_sel(s_q.tcr3[4:3]),
        .tick(tick)
    );

    always_comb begin
        logic wr, rd, gated, hit, crest, trough;
        logic [1:0] di, bi;
        s_d = s_q;
        wr = req.psel & req.penable & req.pwrite & ~s_q.ready;
        rd = req.psel & req.penable & ~req.pwrite & ~s_q.ready;
        di = idx3(req.paddr, TPWM_A_DUTY0);
        bi = idx3(req.paddr, TPWM_A_BUF0);
        gated = req.paddr == TPWM_A_CNT3 || req.paddr == TPWM_A_CNT4 || req.paddr == TPWM_A_PER
            || req.paddr == TPWM_A_DEAD || req.paddr == TPWM_A_CYC || di != 2'h3;
        crest = 1'b0;
        trough = 1'b0;
        hit = 1'b0;
        s_d.ready = req.psel & req.penable & ~s_q.ready;
        s_d.err = 1'b0;
        // counters
        if (tick && rsync) begin
            if (s_q.cnt3 == s_q.per) begin
                s_d.cnt3 = TPWM_ZERO;
                s_d.cnt4 = TPWM_ZERO;
                s_d.phase = ~s_q.phase;
            end else begin
                s_d.cnt3 = s_q.cnt3 + TPWM_ONE;
                s_d.cnt4 = s_q.cnt4 + TPWM_ONE;
                for (int i = 0; i < 3; i++) begin
                    // duty equal period still toggles at the shared point
                    if (s_q.cnt3 + TPWM_ONE == s_q.duty[i]) s_d.phase[i] = ~s_d.phase[i];
                end
            end
        end else if (tick && comp) begin
            // counter three bounces between period and dead time
            if (!s_q.down) begin
                hit = s_q.cnt3 + TPWM_ONE == s_q.per;
                s_d.cnt3 = s_q.cnt3 + TPWM_ONE;
                // counter four moves with counter three and turns at its peaks
                s_d.cnt4 = s_q.cnt4 + TPWM_ONE;
                s_d.sub = s_q.sub + TPWM_ONE;
                if (hit) begin
                    s_d.down = 1'b1;
                    crest = 1'b1;
                end
            end else begin
                hit = s_q.cnt3 - TPWM_ONE == s_q.dead;
                s_d.cnt3 = s_q.cnt3 - TPWM_ONE;
                s_d.cnt4 = s_q.cnt4 - TPWM_ONE;
                s_d.sub = s_q.sub - TPWM_ONE;
                if (hit) begin
                    s_d.down = 1'b0;
                    trough = 1'b1;
                end
            end
            if ((crest || trough) && s_q.ocr[TPWM_B_PERIOD_TOGGLE_ENABLE]) s_d.toggle = ~s_q.toggle;
            // buffer to temp, temp to compare at selected peak
            for (int i = 0; i < 3; i++) begin
                s_d.temp[i] = s_q.buf_r[i];
                if ((crest && s_q.mode3 != TPWM_MD_COMP_TROUGH) ||
                    (trough && s_q.mode3 != TPWM_MD_COMP_CREST)) begin
                    s_d.duty[i] = s_q.temp[i];
                end
                // positive while counter three at or below duty
                s_d.phase[i] = s_d.cnt3 <= s_q.duty[i];
                // negative once counter four passes duty, dead band between
                s_d.neg[i] = (s_d.cnt4 > s_q.duty[i]) ? s_q.ocr[TPWM_B_NEGATIVE_LEVEL_SELECT] : ~s_q.ocr[TPWM_B_NEGATIVE_LEVEL_SELECT];
            end
            if (crest || trough) begin
                if ((crest && s_q.mode3 != TPWM_MD_COMP_TROUGH) || (trough && s_q.mode3 != TPWM_MD_COMP_CREST)) begin
                    s_d.per = s_q.perbuf;
                    s_d.cyc = s_q.cycbuf;
                end
            end
        end
        // output stage
        for (int i = 0; i < 3; i++) begin
            if (rsync) begin
                s_d.pos[i] = s_d.phase[i] ^ ~s_q.ocr[TPWM_B_POSITIVE_LEVEL_SELECT];
                s_d.neg[i] = ~s_d.phase[i] ^ ~s_q.ocr[TPWM_B_NEGATIVE_LEVEL_SELECT];
            end else if (comp) begin
                s_d.pos[i] = s_d.phase[i] ? s_q.ocr[TPWM_B_POSITIVE_LEVEL_SELECT] : ~s_q.ocr[TPWM_B_POSITIVE_LEVEL_SELECT];
            end
        end
        // pins driven only in a pwm mode and when enabled
        s_d.oe_b = {~(comp & s_q.oer[6]), ~({6{rsync | comp}} & s_q.oer[5:0])};
        // register access
        if (wr && !(gated && locked)) begin
            unique case (req.paddr)
                TPWM_A_START: s_d.start = req.pwdata[TPWM_B_CH4_COUNT_START:TPWM_B_CH3_COUNT_START];
                TPWM_A_TCR3: s_d.tcr3 = req.pwdata[7:0];
                TPWM_A_TCR4: s_d.tcr4 = req.pwdata[7:0];
                TPWM_A_MODE3: begin
                    s_d.mode3 = req.pwdata[3:0];
                    // entering complementary mode with both counters stopped loads buffers and dead time
                    if (req.pwdata[3:0] >= TPWM_MD_COMP_CREST && !(s_q.start[0] | s_q.start[1])) begin
                        s_d.cnt3 = s_q.dead;
                        s_d.per = s_q.perbuf;
                        s_d.cyc = s_q.cycbuf;
                        s_d.duty = s_q.buf_r;
                        s_d.temp = s_q.buf_r;
                        s_d.down = 1'b0;
                        // outputs start inactive so no leg sees both switches on
                        s_d.phase = 3'h0;
                        s_d.neg = {3{~s_q.ocr[TPWM_B_NEGATIVE_LEVEL_SELECT]}};
                    end
                end
                TPWM_A_MODE4: s_d.mode4 = req.pwdata[3:0];
                TPWM_A_OCR: s_d.ocr = req.pwdata[7:0];
                TPWM_A_OER: s_d.oer = req.pwdata[7:0];
                TPWM_A_BCR: s_d.bcr = req.pwdata[15:0];
                TPWM_A_CNT3: s_d.cnt3 = req.pwdata[DW-1:0];
                TPWM_A_CNT4: s_d.cnt4 = req.pwdata[DW-1:0];
                TPWM_A_PER: s_d.per = req.pwdata[DW-1:0];
                TPWM_A_PERBUF: s_d.perbuf = req.pwdata[DW-1:0];
                TPWM_A_DEAD: s_d.dead = req.pwdata[DW-1:0];
                TPWM_A_CYC: s_d.cyc = req.pwdata[DW-1:0];
                TPWM_A_CYCBUF: s_d.cycbuf = req.pwdata[DW-1:0];
                default: begin
                    if (di != 2'h3) s_d.duty[di] = req.pwdata[DW-1:0];
                    else if (bi != 2'h3) s_d.buf_r[bi] = req.pwdata[DW-1:0];
                    else if (req.paddr != TPWM_A_SUB) s_d.err = 1'b1;
                end
            endcase
        end else if (wr) begin
            s_d.err = 1'b1;
        end
        if (rd) begin
            s_d.rdata = 32'h0000_0000;
            if (gated && locked) begin
                s_d.err = 1'b1;
            end else begin
                unique case (req.paddr)
                    TPWM_A_START: s_d.rdata = 32'({s_q.start, 6'h00});
                    TPWM_A_TCR3: s_d.rdata = 32'(s_q.tcr3);
                    TPWM_A_TCR4: s_d.rdata = 32'(s_q.tcr4);
                    TPWM_A_MODE3: s_d.rdata = 32'(s_q.mode3);
                    TPWM_A_MODE4: s_d.rdata = 32'(s_q.mode4);
                    TPWM_A_OCR: s_d.rdata = 32'(s_q.ocr);
                    TPWM_A_OER: s_d.rdata = 32'(s_q.oer);
                    TPWM_A_BCR: s_d.rdata = 32'(s_q.bcr);
                    TPWM_A_CNT3: s_d.rdata = zx(s_q.cnt3);
                    TPWM_A_CNT4: s_d.rdata = zx(s_q.cnt4);
                    TPWM_A_PER: s_d.rdata = zx(s_q.per);
                    TPWM_A_PERBUF: s_d.rdata = zx(s_q.perbuf);
                    TPWM_A_DEAD: s_d.rdata = zx(s_q.dead);
                    TPWM_A_CYC: s_d.rdata = zx(s_q.cyc);
                    TPWM_A_CYCBUF: s_d.rdata = zx(s_q.cycbuf);
                    TPWM_A_SUB: s_d.rdata = zx(s_q.sub);
                    default: begin
                        if (di != 2'h3) s_d.rdata = zx(s_q.duty[di]);
                        else if (bi != 2'h3) s_d.rdata = zx(s_q.buf_r[bi]);
                        else s_d.err = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.tcr3 <= TPWM_TCR_RST;
            s_q.oer <= TPWM_OER_RST;
            s_q.bcr <= TPWM_BCR_RST;
            s_q.per <= TPWM_CNT_MAX;
            s_q.perbuf <= TPWM_CNT_MAX;
            s_q.cyc <= TPWM_CNT_MAX;
            s_q.cycbuf <= TPWM_CNT_MAX;
            s_q.oe_b <= 7'h7F;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err;
    assign pins = '{pos: s_q.pos, neg: s_q.neg, toggle: s_q.toggle};
    assign pins_oe_b = s_q.oe_b;
endmodule

// *** bench/tpwm_gate_drv.sv ***
// gate driver model: resolves the seven gate lines and flags shoot-through
`timescale 1ns/1ps
module tpwm_gate_drv import tpwm_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // from the timer
    input wire tpwm_pins_t pins,
    input wire logic [6:0] pins_oe_b,
    // resolved lines and status
    output logic [6:0] line,
    output logic [2:0] shoot
);
    logic [6:0] float_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            float_q <= 7'h55;
        end else begin
            float_q <= ~float_q;
        end
    end
    assign line = ({pins.toggle, pins.pos, pins.neg} & ~pins_oe_b) | (float_q & pins_oe_b);
    // both switches of a leg on
    assign shoot = line[5:3] & line[2:0] & ~pins_oe_b[5:3] & ~pins_oe_b[2:0];
endmodule

// *** bench/tpwm_props.sv ***
// concurrent checks on the apb slave and gate pins of the pwm timer
`timescale 1ns/1ps
module tpwm_props import tpwm_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // gate driver pins
    input wire tpwm_pins_t pins,
    input wire logic [6:0] pins_oe_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic acc1;
    assign acc1 = psel && penable && !pready;
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_ready_answer; acc1 |=> pready; endproperty
    a_ready_answer: assert property (p_ready_answer) else $error("no answer after one wait");
    property p_ready_cause; pready |-> $past(psel && penable); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
    property p_err_with_ready; pslverr |-> pready; endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
    property p_unmapped; acc1 && paddr > TPWM_A_BCR |=> pready && pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_buf_open;
        acc1 && (paddr == TPWM_A_PERBUF || paddr == TPWM_A_CYCBUF || (paddr >= TPWM_A_BUF0 && paddr <= 8'h40))
        |=> !pslverr;
    endproperty
    a_buf_open: assert property (p_buf_open) else $error("buffer access refused");
    property p_sub_ro; acc1 && pwrite && paddr == TPWM_A_SUB |=> !pslverr; endproperty
    a_sub_ro: assert property (p_sub_ro) else $error("subcounter write flagged");
    property p_rdata_hold; $changed(prdata) |-> pready; endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved between reads");
    property p_reset_out; $rose(rst_b) |-> pins_oe_b == 7'h7F && pins == '0; endproperty
    a_reset_out: assert property (p_reset_out) else $error("pins active out of reset");
    property p_dead_gap;
        !pins_oe_b[6] && ($fell(pins.pos[0]) || $fell(pins.neg[0])) |-> !pins.pos[0] && !pins.neg[0];
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("no dead band between leg switches");
    c_write: cover property (acc1 && pwrite ##1 pready);
    c_refused: cover property (pready && pslverr);
    c_enabled: cover property ($fell(pins_oe_b[0]));
endmodule

// *** bench/three_phase_motor_pwm_setup_test.sv ***
// self-checking bench for the three-phase pwm timer
`timescale 1ns/1ps
module three_phase_motor_pwm_setup_test import tpwm_pkg::*;;
    localparam logic [31:0] RS_P = 32'h9;
    localparam logic [31:0] CP_D = 32'h2;
    localparam logic [31:0] CP_C = 32'hA;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    tpwm_pins_t pins;
    logic [6:0] pins_oe_b, line;
    logic [2:0] shoot;
    int n_fail = 0;
    int checks = 0;
    tpwm_top u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .pins_oe_b(pins_oe_b));
    tpwm_gate_drv u_drv (.clk(clk), .rst_b(rst_b), .pins(pins), .pins_oe_b(pins_oe_b), .line(line), .shoot(shoot));
    task automatic final_report;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_rng(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
        checks++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            n_fail++;
            $display("mismatch t=%0t exp=%h..%h got=%h", $time, lo, hi, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, ee}, {31'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic e;
        apb(1'b0, a, 32'h0, v, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic ee);
        logic [31:0] v;
        logic e;
        apb(1'b0, a, 32'h0, v, e);
        chk({31'h0, ee}, {31'h0, e});
        if (!ee) chk(x, v);
    endtask
    task automatic t_reset;
        chk(32'h7F, {25'h0, pins_oe_b});
        chk(32'h0, {25'h0, pins});
        rdc(TPWM_A_OER, {24'h0, TPWM_OER_RST}, 1'b0);
        rdc(TPWM_A_BCR, {16'h0, TPWM_BCR_RST}, 1'b0);
        rdc(TPWM_A_TCR3, {24'h0, TPWM_TCR_RST}, 1'b0);
    endtask
    task automatic t_access;
        wr(TPWM_A_CNT3, 32'h5, 1'b1);
        rdc(TPWM_A_PER, 32'h0, 1'b1);
        wr(TPWM_A_PERBUF, 32'hABCD1234, 1'b0);
        rdc(TPWM_A_PERBUF, 32'h1234, 1'b0);
        wr(TPWM_A_SUB, 32'h7, 1'b0);
        rdc(8'h58, 32'h0, 1'b1);
        wr(TPWM_A_BCR, 32'h2000, 1'b0);
        wr(TPWM_A_CNT3, 32'h5, 1'b0);
        rdc(TPWM_A_CNT3, 32'h5, 1'b0);
    endtask
    task automatic t_rsync;
        logic [31:0] v, prv;
        logic p0;
        int nt;
        logic wrapped;
        wrapped = 1'b0;
        prv = 32'h0;
        wr(TPWM_A_START, 32'h0, 1'b0);
        wr(TPWM_A_TCR3, 32'h0, 1'b0);
        wr(TPWM_A_CNT3, 32'h0, 1'b0);
        wr(TPWM_A_CNT4, 32'h0, 1'b0);
        wr(TPWM_A_PER, RS_P, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(TPWM_A_DUTY0 + 8'(4 * i), (i == 2) ? RS_P : 32'(3 * i + 3), 1'b0);
        end
        wr(TPWM_A_OCR, 32'h43, 1'b0);
        wr(TPWM_A_MODE3, {28'h0, TPWM_MD_RESET_SYNC}, 1'b0);
        wr(TPWM_A_OER, 32'h7F, 1'b0);
        wr(TPWM_A_START, 32'hC0, 1'b0);
        chk(32'h0, {26'h0, pins_oe_b[5:0]});
        repeat (12) begin
            rd(TPWM_A_CNT3, v);
            chk_rng(32'h0, RS_P, v);
            if (v < prv) wrapped = 1'b1;
            prv = v;
            @(negedge clk);
            chk({29'h0, ~pins.pos}, {29'h0, pins.neg});
        end
        chk(32'h1, {31'h0, wrapped});
        p0 = pins.pos[0];
        nt = 0;
        repeat (10 * (RS_P + 1)) begin
            @(negedge clk);
            if (pins.pos[0] !== p0) nt++;
            p0 = pins.pos[0];
        end
        chk_rng(32'd18, 32'd22, nt);
    endtask
    task automatic t_comp(input logic [3:0] md, input logic [7:0] ck);
        logic [31:0] v, prv;
        logic up, dn, tg, tgc;
        wr(TPWM_A_START, 32'h0, 1'b0);
        wr(TPWM_A_MODE3, 32'h0, 1'b0);
        wr(TPWM_A_TCR3, {24'h0, ck}, 1'b0);
        wr(TPWM_A_TCR4, {24'h0, ck}, 1'b0);
        wr(TPWM_A_CNT3, CP_D, 1'b0);
        wr(TPWM_A_CNT4, 32'h0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(TPWM_A_DUTY0 + 8'(4 * i), 32'h5, 1'b0);
            wr(TPWM_A_BUF0 + 8'(4 * i), 32'h5, 1'b0);
        end
        wr(TPWM_A_DEAD, CP_D, 1'b0);
        wr(TPWM_A_CYC, CP_C, 1'b0);
        wr(TPWM_A_CYCBUF, CP_C, 1'b0);
        wr(TPWM_A_PER, CP_C + CP_D, 1'b0);
        wr(TPWM_A_PERBUF, CP_C + CP_D, 1'b0);
        wr(TPWM_A_OCR, 32'h43, 1'b0);
        wr(TPWM_A_MODE3, {28'h0, md}, 1'b0);
        wr(TPWM_A_OER, 32'h7F, 1'b0);
        wr(TPWM_A_START, 32'hC0, 1'b0);
        prv = CP_D;
        up = 1'b0;
        dn = 1'b0;
        tg = pins.toggle;
        tgc = 1'b0;
        repeat (16) begin
            rd(TPWM_A_CNT3, v);
            chk_rng(CP_D, CP_C + CP_D, v);
            if (v > prv) up = 1'b1;
            if (v < prv) dn = 1'b1;
            prv = v;
            rd(TPWM_A_CNT4, v);
            chk_rng(32'h0, CP_C, v);
            @(negedge clk);
            chk(32'h0, {29'h0, shoot});
            if (pins.toggle !== tg) tgc = 1'b1;
        end
        chk(32'h1, {31'h0, up & dn});
        chk(32'h1, {31'h0, tgc});
        chk(32'h0, {25'h0, pins_oe_b});
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(50 * 20000);
        n_fail++;
        final_report();
    end
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        t_reset();
        t_access();
        t_rsync();
        t_comp(TPWM_MD_COMP_CREST, 8'h00);
        t_comp(TPWM_MD_COMP_TROUGH, 8'h00);
        t_comp(TPWM_MD_COMP_BOTH, 8'h09);
        wr(TPWM_A_OER, 32'h0, 1'b0);
        @(negedge clk);
        chk(32'h7F, {25'h0, pins_oe_b});
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        t_reset();
        final_report();
    end
endmodule
bind tpwm_top tpwm_props u_props (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .pins_oe_b(pins_oe_b));
